// >>> core/hbs_top.sv
`timescale 1ns/1ns
module hbs_top
  import hbs_pkg::*;
#(
  parameter int unsigned DW = 16,
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [DW-1:0] speed_cmd,
  input wire logic signed [DW-1:0] speed_act,
  input wire logic pos_start,
  output logic signed [DW-1:0] speed_out,
  output logic pos_start_out,
  output logic hold_position,
  output logic brake_release,
  output logic stage_enable,
  output logic drive_enabled
);
  logic [2:0] ctrl_q; // Enable, torque mode, automatic brake on.
  logic [15:0] run_dly_q; // Release delay in ms.
  logic [15:0] stop_dly_q; // Engage delay in ms.
  logic [15:0] idle_q; // Idle time in ms.
  logic [DW-1:0] zthr_q; // Standstill threshold.
  hbs_state_e state_q;
  hbs_state_e state_d;
  logic [31:0] div_q; // Millisecond prescaler.
  logic tick;
  logic still;
  logic run_done;
  logic stop_done;
  logic idle_done;
  logic en;
  logic torque;
  logic apb_wr;
  logic [31:0] rd_d;

  // Absolute value used by the standstill check.
  function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
    mag = v[DW-1] ? DW'(-v) : DW'(v);
  endfunction

  assign en = ctrl_q[CTRL_ENABLE];
  assign torque = ctrl_q[CTRL_TORQUE];
  assign still = mag(speed_act) <= zthr_q;

  // Zero-wait APB slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;

  // Register writes; unmapped offsets are refused with pslverr.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      run_dly_q <= 16'(RUN_DELAY_MS);
      stop_dly_q <= 16'(STOP_DELAY_MS);
      idle_q <= 16'(IDLE_TIME_MS);
      zthr_q <= DW'(ZERO_SPEED_DEF);
    end
    else if (apb_wr)
    begin
      unique case (paddr)
        OFS_CTRL: ctrl_q <= pwdata[2:0];
        OFS_RUN_DLY: run_dly_q <= pwdata[15:0];
        OFS_STOP_DLY: stop_dly_q <= pwdata[15:0];
        OFS_IDLE: idle_q <= pwdata[15:0];
        OFS_ZTHR: zthr_q <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // Read multiplexer; status shows state, brake and stage.
  always_comb
  begin
    rd_d = 32'h0;
    unique case (paddr)
      OFS_CTRL: rd_d = {29'h0, ctrl_q};
      OFS_RUN_DLY: rd_d = {16'h0, run_dly_q};
      OFS_STOP_DLY: rd_d = {16'h0, stop_dly_q};
      OFS_IDLE: rd_d = {16'h0, idle_q};
      OFS_ZTHR: rd_d = 32'(zthr_q);
      OFS_STATUS: rd_d = {23'h0, drive_enabled, stage_enable,
                          brake_release, state_q};
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= rd_d;
      pslverr <= psel && !penable &&
                 (paddr > OFS_STATUS || paddr[1:0] != 2'b00);
    end
  end

  // Millisecond time base from the system clock.
  always_ff @(posedge clk_sys)
  begin
    if (rst || div_q == TICK_DIV - 1)
    begin
      div_q <= 32'h0;
    end
    else
    begin
      div_q <= div_q + 32'h1;
    end
  end
  assign tick = (div_q == TICK_DIV - 1);

  // Release delay, armed only while releasing.
  hbs_ms_timer #(.W(16)) u_run (
    .clk_sys(clk_sys), .rst(rst), .run(state_q == HBS_RELEASE),
    .tick(tick), .limit(run_dly_q), .done(run_done));
  // Engage delay, armed only while the brake closes.
  hbs_ms_timer #(.W(16)) u_stop (
    .clk_sys(clk_sys), .rst(rst), .run(state_q == HBS_ENGAGE),
    .tick(tick), .limit(stop_dly_q), .done(stop_done));
  // Idle timer; any motion or start restarts it.
  hbs_ms_timer #(.W(16)) u_idle (
    .clk_sys(clk_sys), .rst(rst),
    .run(state_q == HBS_RUN && still && !pos_start && !torque &&
         ctrl_q[CTRL_AUTO]),
    .tick(tick), .limit(idle_q), .done(idle_done));

  // Sequencer next state.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      HBS_OFF:
        if (en)
        begin
          state_d = torque ? HBS_RUN : HBS_RELEASE;
        end
      HBS_RELEASE:
        if (!en)
        begin
          state_d = HBS_STOPPING;
        end
        else if (run_done)
        begin
          state_d = HBS_RUN;
        end
      HBS_RUN:
        if (!en)
        begin
          state_d = torque ? HBS_OFF : HBS_STOPPING;
        end
        else if (idle_done)
        begin
          state_d = HBS_AUTO;
        end
      HBS_STOPPING:
        if (still)
        begin
          state_d = HBS_ENGAGE;
        end
      HBS_ENGAGE:
        if (stop_done)
        begin
          state_d = HBS_OFF;
        end
      HBS_AUTO:
        if (!en)
        begin
          state_d = HBS_OFF;
        end
        else if (pos_start)
        begin
          state_d = HBS_RELEASE;
        end
      default: state_d = HBS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= HBS_OFF;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Drive outputs registered from the next state, except pos_start_out from the current one.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      brake_release <= 1'b0;
      stage_enable <= 1'b0;
      drive_enabled <= 1'b0;
      hold_position <= 1'b0;
      speed_out <= '0;
      pos_start_out <= 1'b0;
    end
    else
    begin
      // Brake stays open until standstill in speed mode; a torque-mode disable closes it at once.
      brake_release <= state_d inside {HBS_RELEASE, HBS_RUN,
                                       HBS_STOPPING};
      stage_enable <= state_d inside {HBS_RELEASE, HBS_RUN,
                                      HBS_STOPPING, HBS_ENGAGE};
      // Status stays enabled through the automatic brake.
      drive_enabled <= state_d != HBS_OFF && state_d != HBS_ENGAGE;
      hold_position <= state_d == HBS_ENGAGE;
      // Setpoint passes only when running; zero elsewhere.
      speed_out <= (state_d == HBS_RUN) ? speed_cmd : '0;
      // Starts are swallowed until the release delay has passed.
      pos_start_out <= state_q == HBS_RUN && pos_start;
    end
  end
endmodule

// >>> core/hbs_pkg.sv
package hbs_pkg;
  // System clock rate and the millisecond time base derived from it.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
  // Default delays in their own units.
  localparam int unsigned RUN_DELAY_MS = 0;
  localparam int unsigned STOP_DELAY_MS = 0;
  localparam int unsigned IDLE_TIME_S = 1;
  localparam int unsigned IDLE_TIME_MS = IDLE_TIME_S * MS_PER_S;
  // Default standstill threshold on measured speed magnitude.
  localparam logic [15:0] ZERO_SPEED_DEF = 16'h0010;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RUN_DLY = 8'h04;
  localparam logic [7:0] OFS_STOP_DLY = 8'h08;
  localparam logic [7:0] OFS_IDLE = 8'h0c;
  localparam logic [7:0] OFS_ZTHR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Control register fields.
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_TORQUE = 1;
  localparam int unsigned CTRL_AUTO = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    HBS_OFF = 6'h01,
    HBS_RELEASE = 6'h02,
    HBS_RUN = 6'h04,
    HBS_STOPPING = 6'h08,
    HBS_ENGAGE = 6'h10,
    HBS_AUTO = 6'h20
  } hbs_state_e;
endpackage

// >>> core/hbs_ms_timer.sv
`timescale 1ns/1ns
// Millisecond delay counter: counts while run is high, restarts when low.
module hbs_ms_timer
  import hbs_pkg::*;
#(
  parameter int unsigned W = 16
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_q; // Elapsed milliseconds.

  // Count ticks while armed; losing the trigger restarts the count.
  always_ff @(posedge clk_sys)
  begin
    if (rst || !run)
    begin
      cnt_q <= '0;
    end
    else if (tick && cnt_q != limit)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // A zero limit expires at once, which is the zero-delay default.
  assign done = run && (cnt_q == limit);
endmodule

// >>> verif/hbs_motor.sv
`timescale 1ns/1ns
// Load model: speed follows the setpoint while the brake is open and the
// stage is on; otherwise the axis coasts down by halving each cycle.
module hbs_motor
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic signed [15:0] speed_out,
  input wire logic brake_release,
  input wire logic stage_enable,
  output logic signed [15:0] speed_act
);
  // Halving settles near zero, so standstill is reached in a few cycles.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      speed_act <= '0;
    else if (brake_release && stage_enable)
      speed_act <= speed_out;
    else
      speed_act <= speed_act >>> 1;
  end
endmodule

// >>> verif/hbs_sva.sv
`timescale 1ns/1ns
// Port checker for the brake sequencer.
module hbs_sva
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic pready,
  input wire logic signed [15:0] speed_act,
  input wire logic pos_start,
  input wire logic signed [15:0] speed_out,
  input wire logic pos_start_out,
  input wire logic hold_position,
  input wire logic brake_release,
  input wire logic stage_enable,
  input wire logic drive_enabled
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Entry to the engage delay from a near standstill.
  sequence still_s;
    $past(speed_act) <= 16'sh0010 && $past(speed_act) >= -16'sh0010;
  endsequence
  pready_on_a: assert property (psel |-> pready)
    else $error("pready low in transfer");
  brake_stage_a: assert property (brake_release |-> stage_enable)
    else $error("brake open with stage off");
  set_zero_a: assert property (!brake_release |-> speed_out == 0)
    else $error("setpoint passed with brake closed");
  start_gate_a: assert property (pos_start_out |-> $past(pos_start))
    else $error("start passed without request");
  hold_entry_a: assert property ($rose(hold_position) |-> still_s)
    else $error("brake engaged while moving");
  brake_close_a: assert property
    ($fell(brake_release) && stage_enable |-> hold_position ##0 still_s)
    else $error("brake closed before standstill");
  hold_exit_a: assert property
    ($fell(hold_position) |-> !stage_enable && !drive_enabled)
    else $error("engage delay left wrongly");
  engage_only_a: assert property
    (stage_enable && !drive_enabled |-> hold_position)
    else $error("stage on while disabled");
  auto_off_a: assert property
    ($fell(stage_enable) && drive_enabled |-> $past(brake_release))
    else $error("auto brake not from run");
endmodule

// >>> verif/hbs_tb_top.sv
`timescale 1ns/1ns
module hbs_tb_top;
  import hbs_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pos_start, pready, pslverr;
  logic pos_start_out, hold_position, brake_release, stage_enable;
  logic drive_enabled, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic signed [15:0] speed_cmd, speed_act, speed_out;
  int errors, n_tests, n;
  // Handy view of the outputs that the waits poll.
  wire [3:0] ob = {drive_enabled, hold_position, stage_enable, brake_release};
  // A short tick keeps millisecond delays at ten cycles each.
  hbs_top #(.TICK_DIV(10)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speed_cmd(speed_cmd),
    .speed_act(speed_act), .pos_start(pos_start), .speed_out(speed_out),
    .pos_start_out(pos_start_out), .hold_position(hold_position),
    .brake_release(brake_release), .stage_enable(stage_enable),
    .drive_enabled(drive_enabled));
  hbs_motor pm_u (
    .clk_sys(clk_sys), .rst(rst), .speed_out(speed_out),
    .brake_release(brake_release), .stage_enable(stage_enable),
    .speed_act(speed_act));
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  // One transfer, then an idle edge so psel never toggles twice at once.
  task apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1 && n < 50);
    if (pready !== 1)
    begin
      chk("pready", 1, 0);
      test_done;
    end
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    apb(0, a, 0, r);
    chk("reg", e, r);
  endtask
  task wt(int b, logic v);
    n = 0;
    while (ob[b] !== v)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 3000)
      begin
        chk("wait", 1, 0);
        test_done;
      end
    end
  endtask
  task t_regs;
    rd(OFS_CTRL, 32'h4);
    rd(OFS_IDLE, 32'h3e8);
    rd(OFS_ZTHR, 32'h10);
    rd(OFS_RUN_DLY, 32'h0);
    rd(OFS_STOP_DLY, 32'h0);
    rd(OFS_STATUS, 32'h1);
    apb(0, 8'h18, 0, r);
    chk("slverr", 1, se);
  endtask
  task t_run;
    apb(1, OFS_RUN_DLY, 3, r);
    speed_cmd <= 16'sh0100;
    pos_start <= 1;
    apb(1, OFS_CTRL, 5, r);
    wt(0, 1);
    n = 0;
    while (speed_out === 0 && n < 100)
    begin
      chk("start", 0, pos_start_out);
      @(posedge clk_sys);
      n++;
    end
    chk("delay", 1, n >= 18 && n < 45);
    repeat (2) @(posedge clk_sys);
    chk("start", 1, pos_start_out);
  endtask
  task t_stop;
    apb(1, OFS_STOP_DLY, 2, r);
    pos_start <= 0;
    apb(1, OFS_CTRL, 4, r);
    @(posedge clk_sys);
    chk("zero", 0, speed_out);
    chk("brake open", 1, brake_release);
    wt(2, 1);
    chk("brake", 0, brake_release);
    wt(1, 0);
    chk("engage", 1, n >= 8);
  endtask
  task t_torque;
    speed_cmd <= 16'sh0040;
    apb(1, OFS_CTRL, 3, r);
    wt(0, 1);
    chk("tq on", 1, n < 4);
    chk("tq set", 16'h0040, speed_out);
    apb(1, OFS_CTRL, 2, r);
    wt(1, 0);
    chk("tq off", 1, n < 4);
  endtask
  task t_auto;
    apb(1, OFS_RUN_DLY, 0, r);
    apb(1, OFS_IDLE, 5, r);
    speed_cmd <= 0;
    apb(1, OFS_CTRL, 5, r);
    wt(1, 1);
    wt(1, 0);
    chk("idle", 1, n >= 40);
    chk("status", 1, drive_enabled);
    rd(OFS_STATUS, 32'h120);
    pos_start <= 1;
    wt(1, 1);
    chk("restart", 1, n < 5);
    pos_start <= 0;
  endtask
  initial
  begin
    errors = 0;
    n_tests = 0;
    {psel, penable, pwrite, pos_start, paddr, pwdata} = '0;
    speed_cmd = 0;
    rst = 1;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    t_regs;
    t_run;
    t_stop;
    t_torque;
    t_auto;
    test_done;
  end
endmodule
bind hbs_top hbs_sva chk_u (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .pready(pready),
  .speed_act(speed_act), .pos_start(pos_start), .speed_out(speed_out),
  .pos_start_out(pos_start_out), .hold_position(hold_position),
  .brake_release(brake_release), .stage_enable(stage_enable),
  .drive_enabled(drive_enabled));
